// ### rtl/pdk_defines.svh
/*
 * Register offsets, field values, reset values and timing counts
 * for the panel dial and key-lock block.
 * Assumes a 100 MHz system clock and a 32-bit APB register bus.
 */
`ifndef PDK_DEFINES_SVH
`define PDK_DEFINES_SVH

`define PDK_REG_RUN_DIR 8'h00
`define PDK_REG_LANG 8'h04
`define PDK_REG_DIAL_LOCK 8'h08
`define PDK_REG_DIAL_STEP 8'h0c
`define PDK_REG_MAX_FREQ 8'h10
`define PDK_REG_EXT_DISP 8'h14
`define PDK_REG_WR_PROT 8'h18
`define PDK_REG_STATUS 8'h1c
`define PDK_REG_FREQ_CMD 8'h20
`define PDK_REG_SET_FREQ 8'h24
`define PDK_REG_DIAL_POS 8'h28

// Dial/lock selection codes (0, 1, 10, 11)
`define PDK_LOCK_FSET 8'h00
`define PDK_LOCK_POT 8'h01
`define PDK_LOCK_FSET_LK 8'h0a
`define PDK_LOCK_POT_LK 8'h0b
`define PDK_LOCK_AVAIL_BIT 3
`define PDK_LOCK_POT_BIT 0

// Dial step codes: off, 0.01, 0.1, 1, 10 (Hz)
`define PDK_STEP_OFF 3'h0
`define PDK_STEP_0P01 3'h1
`define PDK_STEP_0P1 3'h2
`define PDK_STEP_1 3'h3
`define PDK_STEP_10 3'h4
// Step sizes in 0.01 Hz units
`define PDK_INC_0P01 16'h0001
`define PDK_INC_0P1 16'h000a
`define PDK_INC_1 16'h0064
`define PDK_INC_10 16'h03e8
// 100.00 Hz, at or above which the step floor is 0.1 Hz
`define PDK_FLOOR_FREQ 16'h2710

`define PDK_RST_MAX_FREQ 16'h2ee0
`define PDK_LANG_MAX 3'h7
`define PDK_CLICKS_PER_TURN 5'h18

`define PDK_CLK_HZ 100000000
`define PDK_SAVE_S 10
`define PDK_HOLD_S 2
`define PDK_SAVE_CYCLES (`PDK_SAVE_S * `PDK_CLK_HZ)
`define PDK_HOLD_CYCLES (`PDK_HOLD_S * `PDK_CLK_HZ)

`endif

// ### rtl/pdk_panel.sv
/*
 * Front-panel dial and key-lock control: run direction, language code,
 * dial frequency setting, long-press lock, dial step, delayed store.
 * Assumes raw key and detent levels from pins, an APB master on sys_clk,
 * and a store that takes nv_data on the nv_write pulse.
 */
// The APB interface to the registers and the address map were left to the implementer.
// Behaviour
// - Run key starts forward when run direction is 0, reverse when 1.
// - A language code 0 to 7 is held and shown to the parameter unit.
// - Dial/lock 0,1,10,11 decode setting/pot mode and lock availability.
// - Potentiometer mode: dial changes frequency command directly, running or stopped.
// - Set frequency is stored to non-volatile memory 10 s after a change.
// - Dial raising is limited to the maximum frequency, initially 120 Hz.
// - With lock available, a 2 s mode hold locks dial and keys.
// - While locked, a further 2 s mode hold unlocks.
// - Locked shows lock mark; attempts show reject; monitor after 2 s idle.
// - Monitor display and stop key keep working while locked.
// - Step setting 0 gives 0.01 Hz per detent.
// - Step setting accepts off, 0.01, 0.1, 1, 10 as minimum change.
// - Each detent moves frequency by exactly one step.
// - One dial turn counts as 24 detents.
// - Direction, language, lock and step settings writable only with extended display 0.
// - Step setting stays writable while running regardless of write protect.
// - At 100 Hz or more the step is at least 0.1 Hz.
// - Step applies only to set-frequency edits, not other parameters.
`timescale 1ns/100ps
`include "pdk_defines.svh"

module pdk_panel #(
    parameter int unsigned SAVE_CYCLES = `PDK_SAVE_CYCLES,
    parameter int unsigned HOLD_CYCLES = `PDK_HOLD_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pdk_pkg::pdk_keys_t keys_raw,
    input wire logic param_edit,
    output logic motor_run,
    output logic motor_reverse,
    output logic [15:0] freq_cmd,
    output logic nv_write,
    output logic [15:0] nv_data,
    output logic param_inc,
    output logic param_dec,
    output pdk_pkg::pdk_ind_t ind
);
    import pdk_pkg::*;

    localparam int SW = $clog2(SAVE_CYCLES + 1);
    localparam int HW = $clog2(HOLD_CYCLES + 1);
    localparam int NK = 6;
    localparam int K_RUN = 5;
    localparam int K_STOP = 4;
    localparam int K_MODE = 3;
    localparam int K_SET = 2;
    localparam int K_CW = 1;
    localparam int K_CCW = 0;

    // The store guard below watches eight cycles, so the wait must outlast them
    if (SAVE_CYCLES < 8 || HOLD_CYCLES < 2) begin : g_chk
        $error("pdk_panel: store count below 8 or hold count below 2");
    end

    ////////////////////////////////////////////////////////////////////////
    // Settings
    logic run_dir;
    logic [2:0] lang;
    logic [7:0] dial_lock;
    logic [2:0] dial_step;
    logic [15:0] max_freq;
    logic ext_disp;
    logic [1:0] wr_prot;
    logic [15:0] set_freq;
    logic [15:0] pend_freq;
    logic [4:0] dial_pos;
    logic locked;
    logic save_pend;
    pdk_disp_t disp;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a level counts once stages two and three agree
    logic [NK-1:0] raw, s1, s2, s3, filt, filt_q, press;
    assign raw = keys_raw;

    genvar gi;
    for (gi = 0; gi < NK; gi++) begin : g_sync
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                s1[gi] <= 1'b0;
                s2[gi] <= 1'b0;
                s3[gi] <= 1'b0;
                filt[gi] <= 1'b0;
                filt_q[gi] <= 1'b0;
            end else if (ce) begin
                s1[gi] <= raw[gi];
                s2[gi] <= s1[gi];
                s3[gi] <= s2[gi];
                if (s2[gi] == s3[gi]) begin
                    filt[gi] <= s3[gi];
                end
                filt_q[gi] <= filt[gi];
            end
        end
        assign press[gi] = filt[gi] & ~filt_q[gi];
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode and key qualification
    logic lock_avail, pot_mode, click_up, click_dn, attempt;
    assign lock_avail = dial_lock[`PDK_LOCK_AVAIL_BIT];
    assign pot_mode = dial_lock[`PDK_LOCK_POT_BIT];
    // Both directions at once is noise from the detent contacts
    assign click_up = press[K_CW] & ~press[K_CCW] & ~locked;
    assign click_dn = press[K_CCW] & ~press[K_CW] & ~locked;
    assign attempt = locked & |{press[K_RUN], press[K_SET], press[K_CW], press[K_CCW]};

    ////////////////////////////////////////////////////////////////////////
    // Long press of the mode key
    logic [HW-1:0] hold_cnt;
    logic hold_done, long_press;
    assign long_press = filt[K_MODE] & ~hold_done & (hold_cnt == HW'(HOLD_CYCLES - 1));

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hold_cnt <= '0;
            hold_done <= 1'b0;
        end else if (ce) begin
            if (!filt[K_MODE]) begin
                hold_cnt <= '0;
                hold_done <= 1'b0;
            end else if (long_press) begin
                hold_done <= 1'b1; // One toggle per hold
            end else if (!hold_done) begin
                hold_cnt <= hold_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            locked <= 1'b0;
        end else if (ce) begin
            if (!lock_avail) begin
                locked <= 1'b0;
            end else if (long_press) begin
                locked <= ~locked;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock and reject indication with idle timeout
    logic [HW-1:0] idle_cnt;
    logic idle_done;
    assign idle_done = idle_cnt == HW'(HOLD_CYCLES - 1);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            idle_cnt <= '0;
        end else if (ce) begin
            if (filt != '0) begin
                idle_cnt <= '0;
            end else if (!idle_done) begin
                idle_cnt <= idle_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            disp <= PDK_MONITOR;
        end else if (ce) begin
            case (disp)
                PDK_MONITOR: begin
                    if (long_press && lock_avail && !locked) begin
                        disp <= PDK_LOCKED;
                    end else if (attempt) begin
                        disp <= PDK_REJECT;
                    end
                end
                PDK_LOCKED, PDK_REJECT: begin
                    if (!locked || (long_press && lock_avail)) begin
                        disp <= PDK_MONITOR;
                    end else if (attempt) begin
                        disp <= PDK_REJECT;
                    end else if (idle_done) begin
                        disp <= PDK_MONITOR;
                    end
                end
                default: disp <= PDK_MONITOR;
            endcase
        end
    end

    // Monitor outputs stay live whatever the lock state
    assign ind = '{locked, disp == PDK_LOCKED, disp == PDK_REJECT, lang};

    ////////////////////////////////////////////////////////////////////////
    // Run and stop keys
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            motor_run <= 1'b0;
            motor_reverse <= 1'b0;
        end else if (ce) begin
            if (press[K_STOP]) begin
                motor_run <= 1'b0;
            end else if (press[K_RUN] && !locked) begin
                motor_run <= 1'b1;
                motor_reverse <= run_dir;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dial step and new frequency
    logic [15:0] cur, inc, next_freq;
    logic [16:0] sum;
    logic edit_freq, freq_chg;
    assign cur = pot_mode ? freq_cmd : pend_freq;
    assign edit_freq = (click_up | click_dn) & ~param_edit;

    always_comb begin
        case (dial_step)
            `PDK_STEP_0P1: inc = `PDK_INC_0P1;
            `PDK_STEP_1: inc = `PDK_INC_1;
            `PDK_STEP_10: inc = `PDK_INC_10;
            default: inc = `PDK_INC_0P01;
        endcase
        if (cur >= `PDK_FLOOR_FREQ && inc < `PDK_INC_0P1) begin
            inc = `PDK_INC_0P1;
        end
        sum = {1'b0, cur} + {1'b0, inc};
        if (click_up) begin
            next_freq = (sum > {1'b0, max_freq}) ? max_freq : sum[15:0];
        end else begin
            next_freq = (cur > inc) ? cur - inc : 16'h0000;
        end
    end

    assign freq_chg = (edit_freq & pot_mode) | (press[K_SET] & ~locked & ~pot_mode);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pend_freq <= 16'h0000;
            freq_cmd <= 16'h0000;
        end else if (ce) begin
            if (edit_freq) begin
                pend_freq <= next_freq;
                if (pot_mode) begin
                    freq_cmd <= next_freq;
                end
            end else if (press[K_SET] && !locked && !pot_mode) begin
                freq_cmd <= pend_freq;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            param_inc <= 1'b0;
            param_dec <= 1'b0;
        end else if (ce) begin
            param_inc <= click_up & param_edit;
            param_dec <= click_dn & param_edit;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dial_pos <= 5'h00;
        end else if (ce) begin
            if (press[K_CW] && !press[K_CCW]) begin
                dial_pos <= (dial_pos == `PDK_CLICKS_PER_TURN - 5'h01) ? 5'h00
                    : dial_pos + 5'h01;
            end else if (press[K_CCW] && !press[K_CW]) begin
                dial_pos <= (dial_pos == 5'h00) ? `PDK_CLICKS_PER_TURN - 5'h01
                    : dial_pos - 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Delayed store; a fresh change restarts the wait
    logic [SW-1:0] save_cnt;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            save_cnt <= '0;
            save_pend <= 1'b0;
            nv_write <= 1'b0;
            nv_data <= 16'h0000;
            set_freq <= 16'h0000;
        end else if (ce) begin
            nv_write <= 1'b0;
            if (freq_chg) begin
                save_pend <= 1'b1;
                save_cnt <= '0;
            end else if (save_pend) begin
                if (save_cnt == SW'(SAVE_CYCLES - 1)) begin
                    save_pend <= 1'b0;
                    nv_write <= 1'b1;
                    nv_data <= freq_cmd;
                    set_freq <= freq_cmd;
                end else begin
                    save_cnt <= save_cnt + 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: data latched in setup, zero-wait access
    logic cap_done, err_q, wr_err, cfg_ok;
    logic [31:0] rd_val;
    assign pready = psel & penable & ce & cap_done;
    assign pslverr = pready & err_q;
    assign cfg_ok = ~ext_disp & ~(motor_run & (wr_prot == 2'h0));

    always_comb begin
        rd_val = 32'h0000_0000;
        wr_err = 1'b0;
        case (paddr)
            `PDK_REG_RUN_DIR: begin
                rd_val = {31'h0, run_dir};
                wr_err = ~cfg_ok | (pwdata[31:1] != '0);
            end
            `PDK_REG_LANG: begin
                rd_val = {29'h0, lang};
                wr_err = ~cfg_ok | (pwdata[31:3] != '0);
            end
            `PDK_REG_DIAL_LOCK: begin
                rd_val = {24'h0, dial_lock};
                wr_err = ~cfg_ok | !(pwdata == {24'h0, `PDK_LOCK_FSET}
                    || pwdata == {24'h0, `PDK_LOCK_POT}
                    || pwdata == {24'h0, `PDK_LOCK_FSET_LK}
                    || pwdata == {24'h0, `PDK_LOCK_POT_LK});
            end
            `PDK_REG_DIAL_STEP: begin
                rd_val = {29'h0, dial_step};
                // Running and write protect do not block this one
                wr_err = ext_disp | (pwdata > {29'h0, `PDK_STEP_10});
            end
            `PDK_REG_MAX_FREQ: begin
                rd_val = {16'h0, max_freq};
                wr_err = pwdata[31:16] != '0;
            end
            `PDK_REG_EXT_DISP: begin
                rd_val = {31'h0, ext_disp};
                wr_err = pwdata[31:1] != '0;
            end
            `PDK_REG_WR_PROT: begin
                rd_val = {30'h0, wr_prot};
                wr_err = pwdata[31:2] != '0;
            end
            `PDK_REG_STATUS: begin
                rd_val = {26'h0, save_pend, disp, motor_reverse, motor_run, locked};
                wr_err = 1'b1;
            end
            `PDK_REG_FREQ_CMD: begin
                rd_val = {16'h0, freq_cmd};
                wr_err = 1'b1;
            end
            `PDK_REG_SET_FREQ: begin
                rd_val = {16'h0, set_freq};
                wr_err = 1'b1;
            end
            `PDK_REG_DIAL_POS: begin
                rd_val = {27'h0, dial_pos};
                wr_err = 1'b1;
            end
            default: wr_err = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cap_done <= 1'b0;
            err_q <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            if (pready) begin
                cap_done <= 1'b0;
            end else if (psel && !cap_done) begin
                cap_done <= 1'b1;
                prdata <= pwrite ? 32'h0000_0000 : rd_val;
                err_q <= pwrite ? wr_err : (wr_err & (paddr > `PDK_REG_DIAL_POS
                    || paddr[1:0] != 2'h0));
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            run_dir <= 1'b0;
            lang <= 3'h0;
            dial_lock <= `PDK_LOCK_FSET;
            dial_step <= `PDK_STEP_OFF;
            max_freq <= `PDK_RST_MAX_FREQ;
            ext_disp <= 1'b0;
            wr_prot <= 2'h0;
        end else if (pready && pwrite && !err_q) begin
            case (paddr)
                `PDK_REG_RUN_DIR: run_dir <= pwdata[0];
                `PDK_REG_LANG: lang <= pwdata[2:0];
                `PDK_REG_DIAL_LOCK: dial_lock <= pwdata[7:0];
                `PDK_REG_DIAL_STEP: dial_step <= pwdata[2:0];
                `PDK_REG_MAX_FREQ: max_freq <= pwdata[15:0];
                `PDK_REG_EXT_DISP: ext_disp <= pwdata[0];
                `PDK_REG_WR_PROT: wr_prot <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    run_direction_a: assert property (ce && press[K_RUN] && !locked && !press[K_STOP]
        |=> motor_run && motor_reverse == $past(run_dir))
        else $error("run key started wrong direction");
    lock_decode_a: assert property (dial_lock inside {`PDK_LOCK_FSET, `PDK_LOCK_POT,
        `PDK_LOCK_FSET_LK, `PDK_LOCK_POT_LK})
        else $error("illegal dial lock code held");
    pot_direct_a: assert property (ce && click_up && !param_edit && pot_mode
        && freq_cmd < max_freq |=> freq_cmd > $past(freq_cmd))
        else $error("pot mode dial did not raise frequency");
    save_delay_a: assert property (ce && freq_chg |=> !nv_write [*8])
        else $error("store came too early after change");
    max_limit_a: assert property (ce && click_up && !param_edit && pot_mode
        && freq_cmd <= max_freq |=> freq_cmd <= $past(max_freq))
        else $error("dial exceeded maximum frequency");
    lock_toggle_a: assert property (ce && long_press && lock_avail
        |=> locked != $past(locked))
        else $error("long press did not toggle lock");
    reject_show_a: assert property (ce && attempt && !long_press
        |=> disp == PDK_REJECT)
        else $error("locked attempt not rejected");
    stop_locked_a: assert property (ce && press[K_STOP] |=> !motor_run)
        else $error("stop key ignored");
    step_exact_a: assert property (ce && click_up && !param_edit && pot_mode
        && dial_step == `PDK_STEP_1 && {1'b0, freq_cmd} + 17'h00064 <= {1'b0, max_freq}
        |=> freq_cmd == $past(freq_cmd) + `PDK_INC_1)
        else $error("detent step not exact");
    hold_release_a: assert property (ce && !filt[K_MODE]
        |=> locked == $past(locked) || !lock_avail)
        else $error("lock changed without a hold");
endmodule

// ### rtl/pdk_pkg.sv
/*
 * Types shared by the panel dial and key-lock block.
 * Assumes the defines header is compiled alongside.
 */
package pdk_pkg;
    typedef struct packed {
        logic run;
        logic stop;
        logic mode;
        logic set;
        logic cw;
        logic ccw;
    } pdk_keys_t;

    typedef enum logic [1:0] {
        PDK_MONITOR,
        PDK_LOCKED,
        PDK_REJECT
    } pdk_disp_t;

    typedef struct packed {
        logic locked;
        logic lock_ind;
        logic reject_ind;
        logic [2:0] language;
    } pdk_ind_t;
endpackage

// ### verif/pdk_dial_model.sv
/* Operator model: panel keys and the detent setting dial.
   Assumes the bench calls its tasks; levels change just after rising edges. */
`timescale 1ns/100ps
module pdk_dial_model (
    input wire logic sys_clk,
    output pdk_pkg::pdk_keys_t keys_raw
);
    import pdk_pkg::*;
    initial keys_raw = '0;
    // Key released low; gap long enough for the filter to see it
    task automatic press(input int idx, input int len);
        @(posedge sys_clk) keys_raw[idx] <= 1'b1;
        repeat (len) @(posedge sys_clk);
        keys_raw[idx] <= 1'b0;
        repeat (10) @(posedge sys_clk);
        // Callers compare outputs next; step off the edge that updates them
        #1;
    endtask
    // Mode held unbroken for the given count, then released
    task automatic hold_mode(input int len);
        press(3, len);
    endtask
endmodule

// ### verif/pdk_panel_tb.sv
/* Self-checking bench for the panel dial and key-lock block.
   Assumes the operator model drives keys; timer counts are shortened. */
`timescale 1ns/100ps
`include "pdk_defines.svh"
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin \
    fail_count++; $display("CHECK FAILED t=%0t %s", $time, msg); end end
module pdk_panel_tb;
    import pdk_pkg::*;
    localparam int SAVE = 40;
    localparam int HOLD = 20;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, param_edit = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, motor_run, motor_reverse, nv_write, param_inc, param_dec;
    logic [15:0] freq_cmd, nv_data;
    pdk_keys_t keys_raw;
    pdk_ind_t ind;
    int fail_count = 0, check_count = 0, cycles = 0, inc_seen = 0, dec_seen = 0, n;
    pdk_panel #(.SAVE_CYCLES(SAVE), .HOLD_CYCLES(HOLD)) dut_u (.sys_clk(sys_clk),
        .rst(rst), .ce(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .keys_raw(keys_raw), .param_edit(param_edit),
        .motor_run(motor_run), .motor_reverse(motor_reverse), .freq_cmd(freq_cmd),
        .nv_write(nv_write), .nv_data(nv_data), .param_inc(param_inc),
        .param_dec(param_dec), .ind(ind));
    pdk_dial_model op_u (.sys_clk(sys_clk), .keys_raw(keys_raw));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic end_of_test();
        if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard, well above the several hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
        if (param_inc === 1'b1) inc_seen++;
        if (param_dec === 1'b1) dec_seen++;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // No local limit: only the hang guard ends a wait
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic clicks(input int idx, input int cnt);
        repeat (cnt) op_u.press(idx, 6);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        apb(0, `PDK_REG_MAX_FREQ, 0);
        `CHK(rd, 32'h2ee0, "max freq reset")
        apb(1, `PDK_REG_LANG, 8);
        `CHK(err, 1'b1, "language out of range")
        apb(1, `PDK_REG_LANG, 7);
        `CHK(ind.language, `PDK_LANG_MAX, "language held")
        apb(1, `PDK_REG_DIAL_LOCK, 2);
        `CHK(err, 1'b1, "lock code refused")
        apb(0, 8'h30, 0);
        `CHK(err, 1'b1, "unmapped address")
        apb(1, `PDK_REG_DIAL_LOCK, `PDK_LOCK_POT);
        clicks(1, 1);
        `CHK(freq_cmd, `PDK_INC_0P01, "default step, pot mode")
        n = 0;
        while (nv_write !== 1'b1 && n < SAVE + 20) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK(nv_data, `PDK_INC_0P01, "delayed store")
        apb(1, `PDK_REG_DIAL_STEP, `PDK_STEP_10);
        clicks(1, 10);
        `CHK(freq_cmd, 16'h2711, "10 Hz steps")
        apb(1, `PDK_REG_DIAL_STEP, `PDK_STEP_0P01);
        clicks(1, 1);
        `CHK(freq_cmd, 16'h271b, "0.1 Hz floor")
        apb(1, `PDK_REG_DIAL_STEP, `PDK_STEP_10);
        clicks(1, 12);
        `CHK(freq_cmd, `PDK_RST_MAX_FREQ, "max clamp")
        apb(0, `PDK_REG_DIAL_POS, 0);
        `CHK(rd, 32'h0, "24 clicks a turn")
        apb(1, `PDK_REG_RUN_DIR, 1);
        op_u.press(5, 6);
        `CHK({motor_run, motor_reverse}, 2'b11, "run reverse")
        apb(1, `PDK_REG_DIAL_STEP, `PDK_STEP_1);
        `CHK(err, 1'b0, "step writable while running")
        apb(1, `PDK_REG_EXT_DISP, 1);
        apb(1, `PDK_REG_DIAL_STEP, `PDK_STEP_0P1);
        `CHK(err, 1'b1, "step blocked by ext display")
        apb(1, `PDK_REG_EXT_DISP, 0);
        apb(1, `PDK_REG_DIAL_LOCK, `PDK_LOCK_FSET);
        `CHK(err, 1'b1, "lock code blocked while running")
        apb(1, `PDK_REG_WR_PROT, 32'h0000_0001);
        apb(1, `PDK_REG_DIAL_LOCK, `PDK_LOCK_FSET);
        `CHK(err, 1'b0, "lock code with write protect off")
        clicks(0, 1);
        `CHK(freq_cmd, 16'h2ee0, "set mode waits for set key")
        op_u.press(2, 6);
        `CHK(freq_cmd, 16'h2e7c, "set key commits")
        op_u.hold_mode(HOLD + 10);
        `CHK(ind.locked, 1'b0, "no lock with code 0")
        apb(1, `PDK_REG_DIAL_LOCK, `PDK_LOCK_FSET_LK);
        `CHK(err, 1'b0, "lock code 10")
        apb(1, `PDK_REG_DIAL_LOCK, `PDK_LOCK_POT_LK);
        op_u.hold_mode(HOLD / 2);
        `CHK(ind.locked, 1'b0, "short hold ignored")
        op_u.hold_mode(HOLD + 10);
        `CHK({ind.locked, ind.lock_ind}, 2'b11, "long hold locks")
        clicks(0, 1);
        `CHK({freq_cmd, ind.reject_ind}, {16'h2e7c, 1'b1}, "dial ignored")
        op_u.press(4, 6);
        `CHK(motor_run, 1'b0, "stop while locked")
        repeat (HOLD + 10) @(posedge sys_clk);
        #1;
        `CHK(ind.reject_ind, 1'b0, "monitor after idle")
        op_u.hold_mode(HOLD + 10);
        `CHK(ind.locked, 1'b0, "long hold unlocks")
        apb(1, `PDK_REG_RUN_DIR, 32'h0000_0000);
        op_u.press(5, 6);
        `CHK({motor_run, motor_reverse}, 2'b10, "run forward")
        @(posedge sys_clk) param_edit <= 1'b1;
        clicks(1, 1);
        `CHK(inc_seen, 1, "param edit pulse")
        `CHK(freq_cmd, 16'h2e7c, "param edit leaves frequency")
        clicks(0, 1);
        `CHK(dec_seen, 1, "param edit down pulse")
        end_of_test();
    end
endmodule
